// >>> core/hcad_alu.sv
`timescale 1ns/1ps
module hcad_alu (
  input  wire hcad_pkg::hcad_op_t op,
  input  wire logic [7:0]         a,
  input  wire logic [7:0]         b,
  input  wire logic               cin,
  output logic [7:0]              y,
  output logic                    c_out,
  output logic                    nib_out,
  output logic                    z_out,
  output logic                    c_en,
  output logic                    nib_en,
  output logic                    z_en
);

  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [8:0] dif9;
  logic [4:0] dif5;

  // Two's complement add, and subtract as b plus inverted a plus one
  assign sum9 = {1'b0, b} + {1'b0, a};                      // RULE_11
  assign sum5 = {1'b0, b[3:0]} + {1'b0, a[3:0]};
  assign dif9 = {1'b0, b} + {1'b0, ~a} + 9'h001;            // RULE_16
  assign dif5 = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;

  // Operation select; the carry out of a subtract is high when no borrow
  always_comb begin
    y       = b;
    c_out   = cin;
    nib_out = 1'b0;
    c_en    = 1'b0;
    nib_en  = 1'b0;
    z_en    = 1'b1;
    case (op)
      hcad_pkg::OP_MOVE:  y = b;
      hcad_pkg::OP_STORE: begin
        y    = a;
        z_en = 1'b0;
      end
      hcad_pkg::OP_ADD: begin
        y       = sum9[7:0];                                // RULE_10
        c_out   = sum9[8];
        nib_out = sum5[4];
        c_en    = 1'b1;                                     // RULE_15
        nib_en  = 1'b1;
      end
      hcad_pkg::OP_SUB: begin
        y       = dif9[7:0];
        c_out   = dif9[8];                                  // RULE_18
        nib_out = dif5[4];                                  // RULE_18
        c_en    = 1'b1;
        nib_en  = 1'b1;
      end
      hcad_pkg::OP_AND:  y = a & b;
      hcad_pkg::OP_OR:   y = a | b;
      hcad_pkg::OP_XOR:  y = a ^ b;
      hcad_pkg::OP_COM:  y = ~b;
      hcad_pkg::OP_INC:  y = b + 8'h01;
      hcad_pkg::OP_DEC:  y = b - 8'h01;
      hcad_pkg::OP_RL: begin
        y     = {b[6:0], cin};                              // RULE_10
        c_out = b[7];
        c_en  = 1'b1;
        z_en  = 1'b0;
      end
      hcad_pkg::OP_RR: begin
        y     = {cin, b[7:1]};
        c_out = b[0];
        c_en  = 1'b1;
        z_en  = 1'b0;
      end
      hcad_pkg::OP_SWAP: begin
        y    = {b[3:0], b[7:4]};
        z_en = 1'b0;
      end
      hcad_pkg::OP_CLR:  y = 8'h00;
      default:           z_en = 1'b0;
    endcase
    z_out = (y == 8'h00);                                   // RULE_17
  end

endmodule : hcad_alu

// >>> core/hcad_core.sv
`timescale 1ns/1ps
// Functional notes
// (RULE_01) Separate program and data buses, same cycle
// (RULE_02) Each instruction is one 14-bit word
// (RULE_03) Program port delivers one word per cycle
// (RULE_04) Fetch next while current one executes
// (RULE_05) One cycle each; branches flush, take two
// (RULE_06) Program 1024/2048 words, RAM 224 bytes
// (RULE_07) Special registers, counter too, in data map
// (RULE_08) Direct and indirect data addressing
// (RULE_09) Any operation on any register, any mode
// (RULE_10) 8-bit ALU: add, subtract, shift, logic
// (RULE_11) Arithmetic is two's complement
// (RULE_12) Two operands: accumulator plus register or literal
// (RULE_13) One operand: accumulator or data register
// (RULE_14) 8-bit accumulator with no data address
// (RULE_15) ALU updates carry, nibble and zero flags
// (RULE_16) Subtract: carry and nibble flags are inverted borrow
// (RULE_17) Zero flag set when result is zero
// (RULE_18) Subtract carry high means no borrow
module hcad_core #(
  parameter int unsigned PROG_WORDS = hcad_pkg::PROG_WORDS_LARGE
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        ce,
  output logic [hcad_pkg::PC_W-1:0]        prog_addr,
  input  wire logic [hcad_pkg::INSTR_W-1:0] prog_data,
  output logic [7:0]                       acc_out,
  output logic [7:0]                       status_out,
  output logic                             instr_valid
);

  // Only the two documented program store sizes are served
  if (PROG_WORDS != hcad_pkg::PROG_WORDS_SMALL &&
      PROG_WORDS != hcad_pkg::PROG_WORDS_LARGE) begin : g_bad_words
    $error("hcad_core: PROG_WORDS must be 1024 or 2048");      // RULE_06
  end

  localparam logic [hcad_pkg::PC_W-1:0] PC_MASK = hcad_pkg::PC_W'(PROG_WORDS - 1);

  hcad_pkg::hcad_state_t st;
  hcad_pkg::hcad_state_t next_st;

  logic [1:0]          cls;
  hcad_pkg::hcad_op_t  op;
  logic                dest_file;
  logic [6:0]          faddr;
  logic [7:0]          lit;
  logic                exec_file;
  logic                exec_lit;
  logic                exec_goto;
  logic                op_idle;
  logic                op_single;
  logic [7:0]          eff_addr;
  logic                is_sfr;
  logic [7:0]          ram_idx;
  logic [7:0]          ram_rd;
  logic [7:0]          sfr_rd;
  logic [7:0]          file_rd;
  logic [7:0]          alu_b;
  logic [7:0]          alu_y;
  logic                alu_c;
  logic                alu_nib;
  logic                alu_z;
  logic                c_en;
  logic                nib_en;
  logic                z_en;
  logic                wr_file;
  logic                wr_acc;
  logic                ram_wr;
  logic [hcad_pkg::PC_W-1:0] pc_seq;
  logic [hcad_pkg::PC_W-1:0] pc_jump;
  logic [hcad_pkg::PC_W-1:0] pc_computed;

  // Instruction word fields; one word carries a whole instruction
  assign cls       = st.ir[hcad_pkg::CLS_HI:hcad_pkg::CLS_LO];         // RULE_02
  assign op        = hcad_pkg::hcad_op_t'(st.ir[hcad_pkg::OP_HI:hcad_pkg::OP_LO]);
  assign dest_file = st.ir[hcad_pkg::DEST_BIT];
  assign faddr     = st.ir[hcad_pkg::FADDR_HI:0];
  assign lit       = st.ir[hcad_pkg::LIT_HI:0];
  assign op_idle   = (op == hcad_pkg::OP_IDLE0) || (op == hcad_pkg::OP_IDLE1);
  assign op_single = (op >= hcad_pkg::OP_COM) && (op <= hcad_pkg::OP_CLR);

  // A flushed slot executes nothing
  assign exec_file = st.ir_valid && (cls == hcad_pkg::CLS_FILE) && !op_idle;
  assign exec_lit  = st.ir_valid && (cls == hcad_pkg::CLS_LIT) && !op_idle;
  assign exec_goto = st.ir_valid && (cls == hcad_pkg::CLS_GOTO);

  // Address zero redirects through the pointer register
  assign eff_addr = (faddr == hcad_pkg::SFR_INDIRECT) ? st.pointer       // RULE_08
                                                      : {st.status[hcad_pkg::ST_BANK], faddr};
  assign is_sfr   = eff_addr[6:0] < hcad_pkg::SFR_LIMIT;
  assign ram_idx  = eff_addr[7] ? ({1'b0, eff_addr[6:0]} + hcad_pkg::RAM_BANK1_OFS)
                                : ({1'b0, eff_addr[6:0]} - hcad_pkg::RAM_BANK0_OFS);

  // Special register read; the indirect slot reads zero to stop self loops
  always_comb begin
    if (eff_addr[6:0] == hcad_pkg::SFR_PCL) begin
      sfr_rd = st.pc[7:0];                                             // RULE_07
    end else if (eff_addr[6:0] == hcad_pkg::SFR_STATUS) begin
      sfr_rd = st.status;
    end else if (eff_addr[6:0] == hcad_pkg::SFR_POINTER) begin
      sfr_rd = st.pointer;
    end else if (eff_addr[6:0] == hcad_pkg::SFR_PCHI) begin
      sfr_rd = {{(8 - hcad_pkg::PCHI_W){1'b0}}, st.pchi};
    end else begin
      sfr_rd = 8'h00;
    end
  end

  // No special cases: every operand source feeds the same ALU
  assign file_rd = is_sfr ? sfr_rd : ram_rd;                           // RULE_09
  // Single-operand literal forms work on the accumulator and ignore the literal field
  assign alu_b   = !exec_lit ? file_rd : (op_single ? st.acc : lit);   // RULE_12 RULE_13

  // Accumulator is always the other input and has no data address
  hcad_alu u_alu (                                                     // RULE_14
    .op      (op),
    .a       (st.acc),
    .b       (alu_b),
    .cin     (st.status[hcad_pkg::ST_C]),
    .y       (alu_y),
    .c_out   (alu_c),
    .nib_out (alu_nib),
    .z_out   (alu_z),
    .c_en    (c_en),
    .nib_en  (nib_en),
    .z_en    (z_en)
  );

  // Store always targets the file; literal results always land in the accumulator
  assign wr_file = exec_file && (dest_file || (op == hcad_pkg::OP_STORE));
  assign wr_acc  = exec_lit || (exec_file && !dest_file && (op != hcad_pkg::OP_STORE));
  assign ram_wr  = rst_n && ce && wr_file && !is_sfr;                  // A reset edge must not commit a store

  // Data memory has its own bus, so it runs alongside the program fetch
  hcad_data_ram #(
    .DEPTH (hcad_pkg::RAM_BYTES)                                       // RULE_06
  ) u_ram (                                                            // RULE_01
    .ref_clk (ref_clk),
    .ce      (ce),
    .wr_en   (ram_wr),
    .wr_idx  (ram_idx),
    .wr_data (alu_y),
    .rd_idx  (ram_idx),
    .rd_data (ram_rd)
  );

  assign pc_seq      = (st.pc + 11'h001) & PC_MASK;
  assign pc_jump     = st.ir[hcad_pkg::TGT_HI:0] & PC_MASK;
  assign pc_computed = {st.pchi, alu_y} & PC_MASK;

  // Next state: fetch and execute overlap every cycle
  always_comb begin
    next_st          = st;
    next_st.ir       = prog_data;                                      // RULE_03 RULE_04
    next_st.ir_valid = 1'b1;
    next_st.pc       = pc_seq;
    if (wr_acc) begin
      next_st.acc = alu_y;
    end
    // Writes to special registers, program counter included
    if (wr_file && is_sfr) begin
      if (eff_addr[6:0] == hcad_pkg::SFR_PCL) begin
        next_st.pc       = pc_computed;                                // RULE_07
        next_st.ir_valid = 1'b0;                                       // RULE_05
      end else if (eff_addr[6:0] == hcad_pkg::SFR_STATUS) begin
        next_st.status = alu_y & hcad_pkg::STATUS_MASK;
      end else if (eff_addr[6:0] == hcad_pkg::SFR_POINTER) begin
        next_st.pointer = alu_y;
      end else if (eff_addr[6:0] == hcad_pkg::SFR_PCHI) begin
        next_st.pchi = alu_y[hcad_pkg::PCHI_W-1:0];
      end
    end
    // Flags override a direct write to status in the same cycle
    if (exec_file || exec_lit) begin
      if (c_en) begin
        next_st.status[hcad_pkg::ST_C] = alu_c;                        // RULE_15 RULE_16
      end
      if (nib_en) begin
        next_st.status[hcad_pkg::ST_NIB] = alu_nib;                    // RULE_16
      end
      if (z_en) begin
        next_st.status[hcad_pkg::ST_Z] = alu_z;                        // RULE_17
      end
    end
    // The prefetched word is stale after a jump, so it is dropped
    if (exec_goto) begin
      next_st.pc       = pc_jump;
      next_st.ir_valid = 1'b0;                                         // RULE_05
    end
  end

  // All state in one register; clock enable low holds everything
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= hcad_pkg::STATE_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign prog_addr   = st.pc;
  assign acc_out     = st.acc;
  assign status_out  = st.status;
  assign instr_valid = st.ir_valid;

  // Checks tied to the logic above
  AST_FETCH_WORD: assert property (@(posedge ref_clk) disable iff (!rst_n)     // RULE_03
    (ce && !exec_goto && !(wr_file && is_sfr && eff_addr[6:0] == hcad_pkg::SFR_PCL))
      |=> (instr_valid && st.ir == $past(prog_data)))
    else $error("fetched word not captured in one cycle");

  AST_PIPE_STEP: assert property (@(posedge ref_clk) disable iff (!rst_n)      // RULE_04
    (ce && !exec_goto && !wr_file) |=> (prog_addr == (($past(prog_addr) + 11'h001) & PC_MASK)))
    else $error("fetch address did not advance by one");

  AST_BRANCH_TWO: assert property (@(posedge ref_clk) disable iff (!rst_n)     // RULE_05
    (ce && exec_goto) |=> ((!instr_valid && prog_addr == ($past(st.ir[10:0]) & PC_MASK))
      and (ce |=> instr_valid)))
    else $error("branch did not flush exactly one slot");

  AST_PCL_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)      // RULE_07
    (ce && wr_file && is_sfr && eff_addr[6:0] == hcad_pkg::SFR_PCL)
      |=> (prog_addr[7:0] == $past(alu_y) && !instr_valid))
    else $error("write to program counter low byte lost");

  AST_LIT_ADD: assert property (@(posedge ref_clk) disable iff (!rst_n)        // RULE_12
    (ce && exec_lit && op == hcad_pkg::OP_ADD)
      |=> (acc_out == 8'($past(lit) + $past(st.acc))
           && status_out[hcad_pkg::ST_C] == ((9'($past(lit)) + 9'($past(st.acc))) > 9'h0ff)))
    else $error("literal add result or carry wrong");

  AST_SUB_BORROW: assert property (@(posedge ref_clk) disable iff (!rst_n)     // RULE_18
    (ce && exec_lit && op == hcad_pkg::OP_SUB)
      |=> (status_out[hcad_pkg::ST_C] == ($past(lit) >= $past(st.acc))
           && status_out[hcad_pkg::ST_NIB] == ($past(lit[3:0]) >= $past(st.acc[3:0]))))
    else $error("subtract borrow flags wrong");

  AST_ZERO_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)      // RULE_17
    (ce && exec_lit && op == hcad_pkg::OP_XOR)
      |=> (status_out[hcad_pkg::ST_Z] == ($past(lit) == $past(st.acc))))
    else $error("zero flag does not follow result");

  AST_FREEZE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!ce) |=> ($stable(prog_addr) && $stable(acc_out) && $stable(status_out)))
    else $error("state moved while clock enable low");

  AST_ACC_STORE: assert property (@(posedge ref_clk) disable iff (!rst_n)      // RULE_14
    (ce && exec_file && op == hcad_pkg::OP_STORE) |=> $stable(acc_out))
    else $error("store altered the accumulator");

  // Each store to the data memory lands in the same cycle as a fetch
  AST_DATA_PARALLEL: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RULE_01
    ram_wr
      |=> (instr_valid && u_ram.st.mem[$past(ram_idx)] == $past(alu_y)))
    else $error("data store did not land beside the fetch");

  AST_PC_RANGE: assert property (@(posedge ref_clk) disable iff (!rst_n)       // RULE_06
    (prog_addr & ~PC_MASK) == 11'h000)
    else $error("fetch address beyond the fitted program store");

  AST_STATUS_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)    // RULE_07
    (ce && exec_file && !dest_file && op == hcad_pkg::OP_MOVE && eff_addr[6:0] == hcad_pkg::SFR_STATUS)
      |=> (acc_out == $past(status_out)))
    else $error("status not readable as data");

  AST_PCL_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)       // RULE_07
    (ce && exec_file && !dest_file && op == hcad_pkg::OP_MOVE && eff_addr[6:0] == hcad_pkg::SFR_PCL)
      |=> (acc_out == $past(prog_addr[7:0])))
    else $error("program counter not readable as data");

  AST_FILE_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)      // RULE_09
    (ce && exec_file && !dest_file && op == hcad_pkg::OP_MOVE && !is_sfr)
      |=> (acc_out == $past(ram_rd)))
    else $error("data register not moved to the accumulator");

  AST_RL_RESULT: assert property (@(posedge ref_clk) disable iff (!rst_n)      // RULE_10
    (ce && exec_file && !dest_file && op == hcad_pkg::OP_RL)
      |=> (acc_out == {$past(file_rd[6:0]), $past(status_out[hcad_pkg::ST_C])}
           && status_out[hcad_pkg::ST_C] == $past(file_rd[7])))
    else $error("rotate left through carry wrong");

  AST_RR_CARRY: assert property (@(posedge ref_clk) disable iff (!rst_n)       // RULE_15
    (ce && exec_file && op == hcad_pkg::OP_RR)
      |=> (status_out[hcad_pkg::ST_C] == $past(file_rd[0])))
    else $error("rotate right did not move bit 0 into carry");

  AST_SINGLE_ACC: assert property (@(posedge ref_clk) disable iff (!rst_n)     // RULE_13
    (ce && exec_lit && op == hcad_pkg::OP_COM)
      |=> (acc_out == ~$past(acc_out)))
    else $error("single-operand literal form did not use the accumulator");

  AST_NIB_ADD: assert property (@(posedge ref_clk) disable iff (!rst_n)        // RULE_15
    (ce && exec_lit && op == hcad_pkg::OP_ADD)
      |=> (status_out[hcad_pkg::ST_NIB] == ((5'($past(lit[3:0])) + 5'($past(st.acc[3:0]))) > 5'h0f)))
    else $error("nibble carry of add wrong");

  AST_AND_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)       // RULE_10
    (ce && exec_lit && op == hcad_pkg::OP_AND)
      |=> (acc_out == ($past(lit) & $past(acc_out)) && $stable(status_out[hcad_pkg::ST_NIB:hcad_pkg::ST_C])))
    else $error("logic operation wrong or touched carry");

  AST_SUB_RESULT: assert property (@(posedge ref_clk) disable iff (!rst_n)     // RULE_11
    (ce && exec_lit && op == hcad_pkg::OP_SUB)
      |=> (acc_out == 8'($past(lit) - $past(acc_out))))
    else $error("two's complement subtract wrong");

endmodule : hcad_core

// >>> core/hcad_data_ram.sv
`timescale 1ns/1ps
module hcad_data_ram #(
  parameter int unsigned DEPTH = hcad_pkg::RAM_BYTES
) (
  input  wire logic       ref_clk,
  input  wire logic       ce,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_idx,
  input  wire logic [7:0] wr_data,
  input  wire logic [7:0] rd_idx,
  output logic [7:0]      rd_data
);

  if (DEPTH == 0 || DEPTH > 256) begin : g_bad_depth
    $error("hcad_data_ram: DEPTH must lie in 1..256");
  end

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } hcad_ram_t;

  hcad_ram_t st;
  hcad_ram_t next_st;

  // Asynchronous read so an operand is ready in its own execute cycle
  assign rd_data = (32'(rd_idx) < DEPTH) ? st.mem[rd_idx] : 8'h00;

  // Write port; contents are data, so reset leaves them alone
  always_comb begin
    next_st = st;
    if (wr_en && (32'(wr_idx) < DEPTH)) begin
      next_st.mem[wr_idx] = wr_data;
    end
  end

  // Clock enable freezes the array with the rest of the core
  always_ff @(posedge ref_clk) begin
    if (ce) begin
      st <= next_st;
    end
  end

endmodule : hcad_data_ram

// >>> core/hcad_pkg.sv
package hcad_pkg;

  // Widths of the two independent memories
  localparam int unsigned INSTR_W          = 14;
  localparam int unsigned DATA_W           = 8;
  localparam int unsigned PC_W             = 11;
  localparam int unsigned PCHI_W           = 3;
  localparam int unsigned PROG_WORDS_SMALL = 1024;
  localparam int unsigned PROG_WORDS_LARGE = 2048;
  localparam int unsigned RAM_BYTES        = 224;

  // Instruction word fields
  localparam int unsigned CLS_HI   = 13;
  localparam int unsigned CLS_LO   = 12;
  localparam int unsigned OP_HI    = 11;
  localparam int unsigned OP_LO    = 8;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned FADDR_HI = 6;
  localparam int unsigned LIT_HI   = 7;
  localparam int unsigned TGT_HI   = 10;

  // Instruction classes
  localparam logic [1:0] CLS_FILE = 2'h0;
  localparam logic [1:0] CLS_LIT  = 2'h1;
  localparam logic [1:0] CLS_GOTO = 2'h2;

  // Status register layout
  localparam int unsigned ST_C    = 0;
  localparam int unsigned ST_NIB  = 1;
  localparam int unsigned ST_Z    = 2;
  localparam int unsigned ST_BANK = 5;
  localparam logic [7:0]  STATUS_MASK = 8'h27;

  // Special function registers, mirrored in both banks
  localparam logic [6:0] SFR_INDIRECT = 7'h00;
  localparam logic [6:0] SFR_PCL      = 7'h01;
  localparam logic [6:0] SFR_STATUS   = 7'h02;
  localparam logic [6:0] SFR_POINTER  = 7'h03;
  localparam logic [6:0] SFR_PCHI     = 7'h04;
  localparam logic [6:0] SFR_LIMIT    = 7'h10;

  // Offsets that fold both banks of general RAM into one index
  localparam logic [7:0] RAM_BANK0_OFS = 8'h10;
  localparam logic [7:0] RAM_BANK1_OFS = 8'h60;

  // Reset values
  localparam logic [PC_W-1:0]    PC_RESET      = 11'h000;
  localparam logic [INSTR_W-1:0] IR_RESET      = 14'h0000;
  localparam logic [7:0]         ACC_RESET     = 8'h00;
  localparam logic [7:0]         STATUS_RESET  = 8'h00;
  localparam logic [7:0]         POINTER_RESET = 8'h00;
  localparam logic [PCHI_W-1:0]  PCHI_RESET    = 3'h0;

  typedef enum logic [3:0] {
    OP_MOVE, OP_STORE, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_COM,
    OP_INC, OP_DEC, OP_RL, OP_RR, OP_SWAP, OP_CLR, OP_IDLE0, OP_IDLE1
  } hcad_op_t;

  typedef struct packed {
    logic [PC_W-1:0]    pc;
    logic [INSTR_W-1:0] ir;
    logic               ir_valid;
    logic [7:0]         acc;
    logic [7:0]         status;
    logic [7:0]         pointer;
    logic [PCHI_W-1:0]  pchi;
  } hcad_state_t;

  localparam hcad_state_t STATE_RESET = '{
    pc: PC_RESET, ir: IR_RESET, ir_valid: 1'b0, acc: ACC_RESET,
    status: STATUS_RESET, pointer: POINTER_RESET, pchi: PCHI_RESET
  };

endpackage : hcad_pkg

// >>> testbench/hcad_prog_rom.sv
`timescale 1ns/1ps
// Program store model: asynchronous read, one whole word per address
module hcad_prog_rom #(
  parameter int unsigned WORDS = hcad_pkg::PROG_WORDS_LARGE
) (
  input  wire logic [hcad_pkg::PC_W-1:0] addr,
  output logic [hcad_pkg::INSTR_W-1:0]   data
);
  // Filled by the bench before reset is released
  logic [hcad_pkg::INSTR_W-1:0] mem [WORDS];

  // Reads past the fitted size follow the address, so they never look stable
  assign data = (int'(addr) < WORDS) ? mem[addr] : {3'h5, addr};
endmodule : hcad_prog_rom

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0] a;
    logic [3:0] op;
    logic [7:0] b;
    logic [7:0] acc;
    logic [7:0] st;
  } hcad_row_t;

  logic                           ref_clk;
  logic                           rst_n;
  logic                           ce;
  logic [hcad_pkg::PC_W-1:0]      prog_addr;
  logic [hcad_pkg::INSTR_W-1:0]   prog_data;
  logic [7:0]                     acc_out;
  logic [7:0]                     status_out;
  logic                           instr_valid;
  int                             failures;
  int                             tests_run;
  hcad_row_t                      rows [10];
  logic [hcad_pkg::PC_W-1:0]      held;

  hcad_core #(.PROG_WORDS(2048)) dut_u (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .prog_addr   (prog_addr),
    .prog_data   (prog_data),
    .acc_out     (acc_out),
    .status_out  (status_out),
    .instr_valid (instr_valid)
  );

  hcad_prog_rom #(.WORDS(2048)) rom_u (
    .addr (prog_addr),
    .data (prog_data)
  );

  // 25 MHz core clock
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Literal and file instruction words
  function automatic logic [13:0] lw(input logic [3:0] op, input logic [7:0] lit);
    return {hcad_pkg::CLS_LIT, op, lit};
  endfunction : lw

  function automatic logic [13:0] fw(input logic [3:0] op, input logic d, input logic [6:0] a);
    return {hcad_pkg::CLS_FILE, op, d, a};
  endfunction : fw

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask : step

  // Word k has executed once the fetch address has moved on to k+2
  task automatic run_to(input int k);
    for (int n = 0; n < 400; n++) begin
      step;
      if (prog_addr === 11'(k + 2)) return;
    end
    failures++;
    $display("[ERR] %0t fetch address %0d never reached", $time, k + 2);
  endtask : run_to

  task automatic chk_reset;
    chk_val(acc_out, 8'h00);
    chk_val(status_out, 8'h00);
    chk_val(prog_addr, 11'h000);
    chk_val(instr_valid, 1'h0);
  endtask : chk_reset

  task automatic finish_test;
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // Whole run is under a hundred cycles; the bound leaves a wide margin
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    finish_test;
  end

  initial begin
    failures  = 0;
    tests_run = 0;
    rst_n     = 1'h0;
    ce        = 1'h1;
    // Status expected as {zero, nibble_flag, carry}; logic ops keep carry and nibble
    rows = '{
      '{8'h3c, hcad_pkg::OP_ADD, 8'hc4, 8'h00, 8'h07},
      '{8'h0f, hcad_pkg::OP_ADD, 8'h01, 8'h10, 8'h02},
      '{8'h7f, hcad_pkg::OP_ADD, 8'h01, 8'h80, 8'h02},
      '{8'h05, hcad_pkg::OP_SUB, 8'h05, 8'h00, 8'h07},
      '{8'h01, hcad_pkg::OP_SUB, 8'h00, 8'hff, 8'h00},
      '{8'h01, hcad_pkg::OP_SUB, 8'h10, 8'h0f, 8'h01},
      '{8'h80, hcad_pkg::OP_SUB, 8'h7f, 8'hff, 8'h02},
      '{8'hf0, hcad_pkg::OP_AND, 8'h0f, 8'h00, 8'h06},
      '{8'ha0, hcad_pkg::OP_OR,  8'h05, 8'ha5, 8'h02},
      '{8'h5a, hcad_pkg::OP_XOR, 8'h5a, 8'h00, 8'h06}
    };
    // Every unused word is a no-op so a stray fetch does nothing
    for (int i = 0; i < 2048; i++) begin
      rom_u.mem[i] = 14'h3000;
    end
    foreach (rows[i]) begin
      rom_u.mem[2*i]   = lw(hcad_pkg::OP_MOVE, rows[i].a);
      rom_u.mem[2*i+1] = lw(rows[i].op, rows[i].b);
    end
    // Indirect store through the pointer, then direct read back
    rom_u.mem[20] = lw(hcad_pkg::OP_MOVE, 8'h21);
    rom_u.mem[21] = fw(hcad_pkg::OP_STORE, 1'h1, hcad_pkg::SFR_POINTER);
    rom_u.mem[22] = lw(hcad_pkg::OP_MOVE, 8'h99);
    rom_u.mem[23] = fw(hcad_pkg::OP_STORE, 1'h1, hcad_pkg::SFR_INDIRECT);
    rom_u.mem[24] = lw(hcad_pkg::OP_MOVE, 8'h00);
    rom_u.mem[25] = fw(hcad_pkg::OP_MOVE, 1'h0, 7'h21);
    // Rotates through a known carry, on a file register
    rom_u.mem[26] = lw(hcad_pkg::OP_MOVE, 8'h81);
    rom_u.mem[27] = fw(hcad_pkg::OP_STORE, 1'h1, 7'h30);
    rom_u.mem[28] = lw(hcad_pkg::OP_MOVE, 8'hff);
    rom_u.mem[29] = lw(hcad_pkg::OP_ADD, 8'h01);
    rom_u.mem[30] = fw(hcad_pkg::OP_RL, 1'h0, 7'h30);
    rom_u.mem[31] = fw(hcad_pkg::OP_RR, 1'h1, 7'h30);
    rom_u.mem[32] = fw(hcad_pkg::OP_MOVE, 1'h0, 7'h30);
    // Special registers read as data, then a jump whose prefetch must die
    rom_u.mem[33] = fw(hcad_pkg::OP_MOVE, 1'h0, hcad_pkg::SFR_STATUS);
    rom_u.mem[34] = fw(hcad_pkg::OP_MOVE, 1'h0, hcad_pkg::SFR_PCL);
    rom_u.mem[35] = {hcad_pkg::CLS_GOTO, 1'h0, 11'h100};
    rom_u.mem[36] = lw(hcad_pkg::OP_MOVE, 8'hee);
    rom_u.mem[256] = lw(hcad_pkg::OP_MOVE, 8'h42);
    // Single-operand op on the accumulator, then a computed jump through the counter
    rom_u.mem[257] = lw(hcad_pkg::OP_MOVE, 8'h01);
    rom_u.mem[258] = fw(hcad_pkg::OP_STORE, 1'h1, hcad_pkg::SFR_PCHI);
    rom_u.mem[259] = lw(hcad_pkg::OP_MOVE, 8'hdf);
    rom_u.mem[260] = lw(hcad_pkg::OP_COM, 8'h00);
    rom_u.mem[261] = fw(hcad_pkg::OP_STORE, 1'h1, hcad_pkg::SFR_PCL);
    rom_u.mem[262] = lw(hcad_pkg::OP_MOVE, 8'hee);
    rom_u.mem[288] = lw(hcad_pkg::OP_ADD, 8'h22);
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    #1;
    chk_reset;
    step;
    // First word is latched while nothing has executed yet
    chk_val(prog_addr, 11'h001);
    chk_val(instr_valid, 1'h1);
    chk_val(acc_out, 8'h00);
    foreach (rows[i]) begin
      run_to(2 * i + 1);
      chk_val(acc_out, rows[i].acc);
      chk_val(status_out, rows[i].st);
    end
    run_to(25);
    chk_val(acc_out, 8'h99);
    run_to(30);
    chk_val(acc_out, 8'h03);
    chk_val(status_out, 8'h07);
    run_to(32);
    chk_val(acc_out, 8'hc0);
    run_to(33);
    chk_val(acc_out, 8'h03);
    run_to(34);
    chk_val(acc_out, 8'h23);
    step;
    chk_val(prog_addr, 11'h100);
    chk_val(instr_valid, 1'h0);
    step;
    chk_val(acc_out, 8'h23);
    step;
    chk_val(acc_out, 8'h42);
    run_to(260);
    chk_val(acc_out, 8'h20);
    step;
    chk_val(prog_addr, 11'h120);
    chk_val(instr_valid, 1'h0);
    run_to(288);
    chk_val(acc_out, 8'h42);
    // Clock enable low must freeze fetch and execution alike
    @(posedge ref_clk);
    ce <= 1'h0;
    #1;
    held = prog_addr;
    repeat (5) step;
    chk_val(prog_addr, held);
    chk_val(acc_out, 8'h42);
    @(posedge ref_clk);
    ce <= 1'h1;
    // Reset in mid-run restarts the program from word zero
    @(posedge ref_clk);
    rst_n <= 1'h0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    #1;
    chk_reset;
    run_to(1);
    chk_val(acc_out, rows[0].acc);
    finish_test;
  end
endmodule : tb_top
